// ===== design/cmrt_top.sv
// Compare match request timer with AHB-Lite register slave
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmrt_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic standby,
  output logic dma_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic run_reg;
  logic start_rsv_reg;
  logic [1:0] cks_reg;
  logic csr_rsv_reg;
  logic flag_reg;
  logic flag_next;
  logic arm_reg;
  logic arm_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] const_reg;
  logic dma_req_reg;
  logic wr_pend_reg;
  logic rd_wait_reg;
  logic [cmrt_pkg::ADDR_W-1:0] addr_reg;
  logic [31:0] hrdata_reg;

  cmrt_tick_if tk ();

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Standby stops the tick and restarts the divider; timer registers are left as they are
  assign tk.run = run_reg && !standby;
  assign tk.sel = cks_reg;

  cmrt_prescaler i_cmrt_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Read data of each register, unused bits zero
  function automatic logic [15:0] read_mux(
    input logic [cmrt_pkg::ADDR_W-1:0] addr,
    input logic run,
    input logic srsv,
    input logic flag,
    input logic crsv,
    input logic [1:0] cks,
    input logic [15:0] cnt,
    input logic [15:0] cst
  );
    read_mux = '0;
    if (addr == cmrt_pkg::START_ADDR) begin
      read_mux[cmrt_pkg::RUN_BIT] = run;
      read_mux[cmrt_pkg::START_RSV_BIT] = srsv;
    end else if (addr == cmrt_pkg::CSR_ADDR) begin
      read_mux[cmrt_pkg::FLAG_BIT] = flag;
      read_mux[cmrt_pkg::CSR_RSV_BIT] = crsv;
      read_mux[cmrt_pkg::CKS_HI_BIT:cmrt_pkg::CKS_LO_BIT] = cks;
    end else if (addr == cmrt_pkg::COUNTER_ADDR) begin
      read_mux = cnt;
    end else if (addr == cmrt_pkg::CONST_ADDR) begin
      read_mux = cst;
    end
  endfunction : read_mux

  logic addr_ok;
  logic rd_req;
  logic wr_req;
  logic wr_start;
  logic wr_csr;
  logic wr_count;
  logic wr_const;
  logic rd_csr_done;
  logic [15:0] rd_value;

  // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY must not start one
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_req = addr_ok && !hwrite;
  assign wr_req = addr_ok && hwrite;
  assign wr_start = wr_pend_reg && (addr_reg == cmrt_pkg::START_ADDR);
  assign wr_csr = wr_pend_reg && (addr_reg == cmrt_pkg::CSR_ADDR);
  assign wr_count = wr_pend_reg && (addr_reg == cmrt_pkg::COUNTER_ADDR);
  assign wr_const = wr_pend_reg && (addr_reg == cmrt_pkg::CONST_ADDR);
  assign rd_csr_done = rd_wait_reg && (addr_reg == cmrt_pkg::CSR_ADDR);
  assign rd_value = read_mux(addr_reg, run_reg, start_rsv_reg, flag_reg, csr_rsv_reg, cks_reg,
                             count_reg, const_reg);

  // Reads take one wait state so a write just before is already visible
  assign hreadyout = !rd_wait_reg;
  assign hresp = cmrt_pkg::HRESP_OKAY;
  assign hrdata = hrdata_reg;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      wr_pend_reg <= wr_req;
      rd_wait_reg <= rd_req;
      if (addr_ok) begin
        addr_reg <= haddr[cmrt_pkg::ADDR_W-1:0];
      end
    end
  end

  // Read data held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (rd_wait_reg) begin
      hrdata_reg <= {16'h0000, rd_value};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Writes apply the whole word; unused bits are simply not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
      start_rsv_reg <= 1'b0;
      cks_reg <= cmrt_pkg::CKS_RST;
      csr_rsv_reg <= 1'b0;
    end else begin
      if (wr_start) begin
        run_reg <= hwdata[cmrt_pkg::RUN_BIT];
        start_rsv_reg <= hwdata[cmrt_pkg::START_RSV_BIT];
      end
      if (wr_csr) begin
        cks_reg <= hwdata[cmrt_pkg::CKS_HI_BIT:cmrt_pkg::CKS_LO_BIT];
        csr_rsv_reg <= hwdata[cmrt_pkg::CSR_RSV_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  logic tick;
  logic at_match;
  logic match_pulse;
  logic flag_clr;

  assign tick = tk.tick;
  assign at_match = (count_reg == const_reg);
  // Equality alone does nothing; the next tick ends the matching count
  assign match_pulse = tick && at_match;

  // Software write beats a tick in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = hwdata[15:0];
    end else if (match_pulse) begin
      count_next = cmrt_pkg::COUNTER_RST;
    end else if (tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= cmrt_pkg::COUNTER_RST;
      const_reg <= cmrt_pkg::CONST_RST;
    end else begin
      count_reg <= count_next;
      if (wr_const) begin
        const_reg <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Match flag with read-before-clear
  // ----------------------------------------------------------------
  // Arming happens when software has seen the flag as one
  assign flag_clr = wr_csr && !hwdata[cmrt_pkg::FLAG_BIT] && arm_reg;

  // A new match in the clearing cycle keeps the flag set
  always_comb begin
    flag_next = flag_reg;
    arm_next = arm_reg;
    if (match_pulse) begin
      flag_next = 1'b1;
    end else if (flag_clr) begin
      flag_next = 1'b0;
    end
    if (flag_clr) begin
      arm_next = 1'b0;
    end else if (rd_csr_done && flag_reg) begin
      arm_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
      arm_reg <= 1'b0;
      dma_req_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      arm_reg <= arm_next;
      dma_req_reg <= match_pulse;
    end
  end

  // One-cycle request per match
  assign dma_req = dma_req_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_halt_freeze: assert property (
    !run_reg && !wr_count |=> $stable(count_reg))
    else $error("counter moved while halted");

  a_tick_spacing: assert property (
    tick |=> !tick [*3])
    else $error("ticks closer than four cycles");

  a_slow_rate: assert property (
    tick && cks_reg == cmrt_pkg::CKS_DIV8 && !wr_csr |=> !tick [*7])
    else $error("divide by eight ticks too soon");

  a_count_step: assert property (
    tick && !at_match && !wr_count |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_match_clear: assert property (
    match_pulse && !wr_count |=> count_reg == cmrt_pkg::COUNTER_RST && flag_reg)
    else $error("match did not clear counter and set flag");

  a_no_early_match: assert property (
    $rose(flag_reg) |-> $past(tick) && $past(at_match))
    else $error("flag set without a tick at equality");

  a_flag_unarmed: assert property (
    flag_reg && !arm_reg |=> flag_reg)
    else $error("flag cleared without a prior read");

  a_dma_pulse: assert property (
    match_pulse |=> dma_req ##1 !dma_req)
    else $error("transfer request not a single pulse");

  a_unused_zero: assert property (
    hreadyout && $past(rd_wait_reg) && addr_reg == cmrt_pkg::CSR_ADDR |-> hrdata[31:8] == 24'h000000
      && hrdata[5:2] == 4'h0)
    else $error("unused control bits read nonzero");

  a_const_write: assert property (
    wr_const |=> const_reg == $past(hwdata[15:0]))
    else $error("constant write lost");

  a_reserved_keep: assert property (
    wr_csr |=> csr_rsv_reg == $past(hwdata[cmrt_pkg::CSR_RSV_BIT]))
    else $error("reserved control bit not stored");

  a_standby_hold: assert property (
    standby && !wr_pend_reg |=> $stable(count_reg) && $stable(const_reg) && $stable(run_reg))
    else $error("register changed in standby");

endmodule : cmrt_top
`default_nettype wire

// ===== design/cmrt_pkg.sv
// Constants shared by the compare match request timer and its prescaler
package cmrt_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] START_IDX = 12'h070;
  localparam logic [ADDR_W-1:0] CSR_IDX = 12'h072;
  localparam logic [ADDR_W-1:0] COUNTER_IDX = 12'h074;
  localparam logic [ADDR_W-1:0] CONST_IDX = 12'h076;
  // Byte address is four times the index
  localparam logic [ADDR_W-1:0] START_ADDR = START_IDX << 2;
  localparam logic [ADDR_W-1:0] CSR_ADDR = CSR_IDX << 2;
  localparam logic [ADDR_W-1:0] COUNTER_ADDR = COUNTER_IDX << 2;
  localparam logic [ADDR_W-1:0] CONST_ADDR = CONST_IDX << 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int START_RSV_BIT = 1;
  localparam int CKS_LO_BIT = 0;
  localparam int CKS_HI_BIT = 1;
  localparam int CSR_RSV_BIT = 6;
  localparam int FLAG_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] CONST_RST = 16'hffff;
  localparam logic [1:0] CKS_RST = 2'h0;

  // ----------------------------------------------------------------
  // Clock select codes and divider masks
  // ----------------------------------------------------------------
  localparam logic [1:0] CKS_DIV4 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  localparam logic [1:0] CKS_DIV64 = 2'h3;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] MASK_DIV4 = 6'h03;
  localparam logic [DIV_W-1:0] MASK_DIV8 = 6'h07;
  localparam logic [DIV_W-1:0] MASK_DIV16 = 6'h0f;
  localparam logic [DIV_W-1:0] MASK_DIV64 = 6'h3f;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : cmrt_pkg

// ===== design/cmrt_tick_if.sv
// Carrier between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface cmrt_tick_if;
  logic [1:0] sel;
  logic run;
  logic tick;
  modport core (output sel, output run, input tick);
  modport prescaler (input sel, input run, output tick);
endinterface : cmrt_tick_if
`default_nettype wire

// ===== design/cmrt_prescaler.sv
// Prescaler that makes the selected counting enable pulse
`timescale 1ns/1ps
`default_nettype none
module cmrt_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  cmrt_tick_if.prescaler tk
);

  // ----------------------------------------------------------------
  // Divider mask for each clock select code
  // ----------------------------------------------------------------
  function automatic logic [cmrt_pkg::DIV_W-1:0] div_mask(input logic [1:0] sel);
    unique case (sel)
      cmrt_pkg::CKS_DIV4: div_mask = cmrt_pkg::MASK_DIV4;
      cmrt_pkg::CKS_DIV8: div_mask = cmrt_pkg::MASK_DIV8;
      cmrt_pkg::CKS_DIV16: div_mask = cmrt_pkg::MASK_DIV16;
      cmrt_pkg::CKS_DIV64: div_mask = cmrt_pkg::MASK_DIV64;
    endcase
  endfunction : div_mask

  logic [cmrt_pkg::DIV_W-1:0] div_reg;
  logic [cmrt_pkg::DIV_W-1:0] div_next;
  logic [cmrt_pkg::DIV_W-1:0] mask;

  // Divider restarts while halted, so the first tick is a full period
  assign div_next = tk.run ? div_reg + cmrt_pkg::DIV_ONE : '0;
  assign mask = div_mask(tk.sel);
  assign tk.tick = tk.run && ((div_reg & mask) == mask);

  // Divider counter, cleared while halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule : cmrt_prescaler
`default_nettype wire

// ===== bench/cmrt_dma_model.sv
// Behavioural DMA controller that takes compare match transfer requests
`timescale 1ns/1ps
`default_nettype none
module cmrt_dma_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dma_req,
  output var int req_count,
  output var int last_gap,
  output var logic wide_seen
);
  int since;
  logic req_d;
  // Take each request pulse and measure the spacing between requests
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_count <= 0;
      last_gap <= 0;
      since <= 0;
      req_d <= 1'b0;
      wide_seen <= 1'b0;
    end else begin
      req_d <= dma_req;
      since <= (dma_req === 1'b1) ? 1 : since + 1;
      if (dma_req === 1'b1) begin
        req_count <= req_count + 1;
        last_gap <= since;
      end
      // A request held two cycles would be taken twice
      if (dma_req === 1'b1 && req_d === 1'b1) begin
        wide_seen <= 1'b1;
      end
    end
  end
endmodule : cmrt_dma_model
`default_nettype wire

// ===== bench/test_compare_match_request_timer.sv
// Self-checking bench for the compare match request timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) check_val(32'(a), 32'(e))
module test_compare_match_request_timer;
  typedef struct packed {logic [11:0] a; logic [31:0] wd; logic [31:0] exp;} cmrt_row_t;
  logic hclk, hresetn, hsel, hwrite, standby, hreadyout, hresp, dma_req, wide;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v, v2;
  wire logic hready;
  int miscompares, num_checks, req_cnt, gap;
  int divs [4] = '{4, 8, 16, 64};
  // Start row last: the counter row must be written and read back while counting is halted
  cmrt_row_t rows [5] = '{
    '{cmrt_pkg::CSR_ADDR, 32'h0000_ffff, 32'h0000_0043},
    '{cmrt_pkg::COUNTER_ADDR, 32'h1234_abcd, 32'h0000_abcd},
    '{cmrt_pkg::CONST_ADDR, 32'h5555_0010, 32'h0000_0010},
    '{12'h000, 32'hffff_ffff, 32'h0000_0000},
    '{cmrt_pkg::START_ADDR, 32'hffff_ffff, 32'h0000_0003}};

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  cmrt_top i_cmrt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .standby(standby), .dma_req(dma_req));
  cmrt_dma_model i_cmrt_dma_model (.hclk(hclk), .hresetn(hresetn), .dma_req(dma_req),
    .req_count(req_cnt), .last_gap(gap), .wide_seen(wide));

  // ----------------------------------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Bus master: entered just after a rising edge
  // ----------------------------------------------------------------
  // Ready and read data are taken at the rising edge, before the slave's flops update
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= cmrt_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task check_reset();
    xfer(0, cmrt_pkg::START_ADDR, 0, v);
    `CHK(v, 0);
    xfer(0, cmrt_pkg::CSR_ADDR, 0, v);
    `CHK(v, 0);
    xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v);
    `CHK(v, 0);
    xfer(0, cmrt_pkg::CONST_ADDR, 0, v);
    `CHK(v, 32'h0000_ffff);
    `CHK(hresp, cmrt_pkg::HRESP_OKAY);
  endtask : check_reset

  // Watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    standby <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    $display("test reset done");
    // Register rows: write, then read back
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].wd, v);
      xfer(0, rows[i].a, 0, v);
      `CHK(v, rows[i].exp);
    end
    // Halt again so every clock select case starts from a stopped counter
    xfer(1, cmrt_pkg::START_ADDR, 0, v);
    $display("test registers done");
    // Each clock select: about ten ticks, then freeze and resume
    for (int c = 0; c < 4; c++) begin
      xfer(1, cmrt_pkg::COUNTER_ADDR, 0, v);
      xfer(1, cmrt_pkg::CONST_ADDR, 32'hffff, v);
      xfer(1, cmrt_pkg::CSR_ADDR, 32'(c), v);
      xfer(1, cmrt_pkg::START_ADDR, 1, v);
      repeat (divs[c] * 10 + divs[c] / 2) @(posedge hclk);
      xfer(1, cmrt_pkg::START_ADDR, 0, v);
      xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v);
      `CHK(v >= 9 && v <= 11, 1);
      repeat (100) @(posedge hclk);
      xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v2);
      `CHK(v2, v);
      xfer(1, cmrt_pkg::START_ADDR, 1, v2);
      repeat (divs[c] * 2 + divs[c] / 2) @(posedge hclk);
      xfer(1, cmrt_pkg::START_ADDR, 0, v2);
      xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v2);
      `CHK(v2 >= v + 1 && v2 <= v + 3, 1);
    end
    $display("test clock select done");
    // Short period: constant 3 at divide by 4 gives four ticks per match
    xfer(1, cmrt_pkg::CSR_ADDR, 0, v);
    xfer(1, cmrt_pkg::COUNTER_ADDR, 0, v);
    xfer(1, cmrt_pkg::CONST_ADDR, 3, v);
    xfer(1, cmrt_pkg::START_ADDR, 1, v);
    repeat (90) @(posedge hclk);
    xfer(1, cmrt_pkg::START_ADDR, 0, v);
    `CHK(gap, 16);
    `CHK(req_cnt >= 4, 1);
    `CHK(wide, 0);
    xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v);
    `CHK(v <= 3, 1);
    // Flag: a clear before any read of one must not take
    xfer(1, cmrt_pkg::CSR_ADDR, 0, v);
    xfer(0, cmrt_pkg::CSR_ADDR, 0, v);
    `CHK(v, 32'h80);
    xfer(1, cmrt_pkg::CSR_ADDR, 32'h80, v);
    xfer(0, cmrt_pkg::CSR_ADDR, 0, v);
    `CHK(v, 32'h80);
    xfer(1, cmrt_pkg::CSR_ADDR, 0, v);
    xfer(0, cmrt_pkg::CSR_ADDR, 0, v);
    `CHK(v, 0);
    $display("test match done");
    // Standby keeps counter and registers while the bus still works
    xfer(1, cmrt_pkg::START_ADDR, 1, v);
    repeat (50) @(posedge hclk);
    standby <= 1'b1;
    xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v);
    repeat (200) @(posedge hclk);
    xfer(0, cmrt_pkg::COUNTER_ADDR, 0, v2);
    `CHK(v2, v);
    xfer(0, cmrt_pkg::START_ADDR, 0, v2);
    `CHK(v2, 1);
    xfer(0, cmrt_pkg::CONST_ADDR, 0, v2);
    `CHK(v2, 3);
    standby <= 1'b0;
    $display("test standby done");
    // Reset in mid-run
    repeat (30) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : test_compare_match_request_timer
`default_nettype wire
